// File: cgm_map.vh
// constants for the clock generator mode-control block
`ifndef CGM_MAP_VH
`define CGM_MAP_VH
// register offsets
`define CGM_OFS_CTRL1 4'h0
`define CGM_OFS_CTRL2 4'h1
`define CGM_OFS_RANGE 4'h2
`define CGM_OFS_PLLC 4'h3
`define CGM_OFS_STAT 4'h4
`define CGM_OFS_STOP 4'h5
// source select encodings
`define CGM_SRC_LOOP 2'h0
`define CGM_SRC_INT 2'h1
`define CGM_SRC_EXT 2'h2
// stop kinds
`define CGM_STOP_NONE 2'h0
`define CGM_STOP_NORMAL 2'h1
`define CGM_STOP_VERY_LOW_POWER_STOP 2'h2
`define CGM_STOP_LLS 2'h3
// fields of control 1
`define CGM_C1_SRC_HI 7
`define CGM_C1_SRC_LO 6
`define CGM_C1_REFSEL 2
`define CGM_C1_IREN 1
`define CGM_C1_IRSTOP 0
// fields of control 2
`define CGM_C2_LP 1
`define CGM_C2_IRSPEED 0
// fields of pll control
`define CGM_PC_OUTEN 6
`define CGM_PC_STOPKEEP 5
`define CGM_PC_PLLSEL 4
// fields of status
`define CGM_ST_UNLOCK 5
// reset values
`define CGM_C1_RST 8'h04
`define CGM_C2_RST 8'h00
`define CGM_RANGE_RST 2'h0
`define CGM_PC_RST 8'h00
// timing
`define CGM_FLL_ACQ_US 1000
`define CGM_RANGE_SW_CYC 2'h3
`define CGM_SWITCH_CYC 4
`endif

// File: cgm_mode_ctrl.v
// mode control for the clock generator: modes, stop behaviour, switch status
//
// Local design decisions: the plain strobed port and the register offsets.
`default_nettype none
`include "cgm_map.vh"
module cgm_mode_ctrl #(
  parameter integer CLK_MHZ = 100,
  parameter integer FLL_ACQ_CYC = `CGM_FLL_ACQ_US * CLK_MHZ
) (
  // clock and reset
  input wire sys_clk_i,
  input wire srst_i,
  // register port
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  // chip stop state
  input wire [1:0] stop_kind_i,
  // clock availability, from other clock domains
  input wire ext_ref_ok_i,
  input wire int_ref_ok_i,
  input wire pll_lock_raw_i,
  // clock gating and selection
  output reg [1:0] main_sel_o,
  output reg fll_enable_o,
  output reg pll_enable_o,
  output reg pll_clk_gate_o,
  output reg ir_clk_gate_o,
  output reg fll_locked_o,
  output reg [1:0] dco_range_o
);
  //////////////////////////////////////////////////////////////////////
  reg [1:0] source_select_r;
  reg reference_select_r;
  reg internal_ref_out_enable_r;
  reg internal_ref_stop_keep_r;
  reg low_power_bypass_r;
  reg internal_ref_speed_r;
  reg pll_out_enable_r;
  reg pll_stop_keep_bit_r;
  reg pll_select_r;
  reg [1:0] osc_range_select_r;
  reg [1:0] range_rb_r;
  reg [1:0] source_status_r;
  reg reference_status_r;
  reg pll_locked_flag_r;
  reg pll_unlock_event_r;
  reg [1:0] stop_r;
  reg [1:0] stop_src_r;
  reg stop_pll_r;
  reg [1:0] sw_cnt_r;
  reg [1:0] rsw_cnt_r;
  reg [31:0] acq_cnt_r;
  reg [1:0] dco_cnt_r;
  reg ext_s1_r, ext_s2_r, int_s1_r, int_s2_r, lck_s1_r, lck_s2_r;
  reg [1:0] stop_s1_r, stop_s2_r;
  wire in_stop;
  wire bypass_lowpower_external;
  wire bypass_lowpower_internal;
  wire src_ok;
  // decoded write strobes
  wire wr_c1;
  wire wr_c2;
  wire wr_rng;
  wire wr_pllc;
  wire wr_stat;
  // gated clocks allowed to run in the present stop kind
  wire pll_keep;
  wire ir_keep;

  function src_avail;
    input [1:0] s;
    input e;
    input i;
    begin
      case (s)
        `CGM_SRC_EXT: src_avail = e;
        `CGM_SRC_INT: src_avail = i;
        default: src_avail = 1'b1;
      endcase
    end
  endfunction

  // one decode for every gated clock, so stop kinds cannot drift apart
  function clk_keep;
    input [1:0] kind;
    input normal_ok;
    input very_low_power_stop_ok;
    begin
      case (kind)
        `CGM_STOP_NONE: clk_keep = 1'b1;
        `CGM_STOP_NORMAL: clk_keep = normal_ok;
        `CGM_STOP_VERY_LOW_POWER_STOP: clk_keep = very_low_power_stop_ok;
        default: clk_keep = 1'b0;
      endcase
    end
  endfunction

  assign in_stop = (stop_s2_r != `CGM_STOP_NONE);
  assign bypass_lowpower_external = (source_select_r == `CGM_SRC_EXT) && !reference_select_r && low_power_bypass_r;
  assign bypass_lowpower_internal = (source_select_r == `CGM_SRC_INT) && reference_select_r && low_power_bypass_r;
  assign src_ok = src_avail(source_select_r, ext_s2_r, int_s2_r);
  assign wr_c1 = wr_i && (addr_i == `CGM_OFS_CTRL1);
  assign wr_c2 = wr_i && (addr_i == `CGM_OFS_CTRL2);
  assign wr_rng = wr_i && (addr_i == `CGM_OFS_RANGE) && !low_power_bypass_r;
  assign wr_pllc = wr_i && (addr_i == `CGM_OFS_PLLC);
  assign wr_stat = wr_i && (addr_i == `CGM_OFS_STAT);
  // pll clock never survives a low-power stop
  assign pll_keep = clk_keep(stop_s2_r, pll_stop_keep_bit_r, 1'b0);
  assign ir_keep = clk_keep(stop_s2_r, internal_ref_stop_keep_r,
    internal_ref_stop_keep_r && internal_ref_speed_r);

  //////////////////////////////////////////////////////////////////////
  // synchronisers for inputs from other domains
  // no reset: they flush within two cycles of any reset pulse
  always @(posedge sys_clk_i) begin
    ext_s1_r <= ext_ref_ok_i;
    ext_s2_r <= ext_s1_r;
  end

  always @(posedge sys_clk_i) begin
    int_s1_r <= int_ref_ok_i;
    int_s2_r <= int_s1_r;
  end

  always @(posedge sys_clk_i) begin
    lck_s1_r <= pll_lock_raw_i;
    lck_s2_r <= lck_s1_r;
  end

  // stop kind is a level; both bits may skew by a cycle on a change
  always @(posedge sys_clk_i) begin
    stop_s1_r <= stop_kind_i;
    stop_s2_r <= stop_s1_r;
  end

  //////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      source_select_r <= `CGM_SRC_LOOP;
      reference_select_r <= 1'b1;
      internal_ref_out_enable_r <= 1'b0;
      internal_ref_stop_keep_r <= 1'b0;
      low_power_bypass_r <= 1'b0;
      internal_ref_speed_r <= 1'b0;
      pll_out_enable_r <= 1'b0;
      pll_stop_keep_bit_r <= 1'b0;
      pll_select_r <= 1'b0;
      osc_range_select_r <= `CGM_RANGE_RST;
      range_rb_r <= `CGM_RANGE_RST;
      source_status_r <= `CGM_SRC_LOOP;
      reference_status_r <= 1'b1;
      pll_locked_flag_r <= 1'b0;
      pll_unlock_event_r <= 1'b0;
      stop_r <= `CGM_STOP_NONE;
      stop_src_r <= `CGM_SRC_LOOP;
      stop_pll_r <= 1'b0;
      sw_cnt_r <= 2'h0;
      rsw_cnt_r <= 2'h0;
      acq_cnt_r <= 32'h0;
      dco_cnt_r <= 2'h0;
      rdata_o <= 8'h00;
    end else begin
      // software writes are taken at any time, except range writes while the low-power bit is set
      if (wr_c1) begin
        source_select_r <= wdata_i[`CGM_C1_SRC_HI:`CGM_C1_SRC_LO];
        reference_select_r <= wdata_i[`CGM_C1_REFSEL];
        internal_ref_out_enable_r <= wdata_i[`CGM_C1_IREN];
        internal_ref_stop_keep_r <= wdata_i[`CGM_C1_IRSTOP];
      end
      if (wr_c2) begin
        low_power_bypass_r <= wdata_i[`CGM_C2_LP];
        internal_ref_speed_r <= wdata_i[`CGM_C2_IRSPEED];
      end
      if (wr_rng) begin
        osc_range_select_r <= wdata_i[1:0];
        dco_cnt_r <= `CGM_RANGE_SW_CYC;
        acq_cnt_r <= FLL_ACQ_CYC;
      end
      if (wr_pllc) begin
        pll_out_enable_r <= wdata_i[`CGM_PC_OUTEN];
        pll_stop_keep_bit_r <= wdata_i[`CGM_PC_STOPKEEP];
        pll_select_r <= wdata_i[`CGM_PC_PLLSEL];
      end
      // unlock event is sticky; set wins over a clear write
      if (wr_stat && wdata_i[`CGM_ST_UNLOCK])
        pll_unlock_event_r <= 1'b0;
      // countdown first, so a later reload in this cycle wins
      if (acq_cnt_r != 32'h0 && !wr_rng)
        acq_cnt_r <= acq_cnt_r - 32'h1;
      // reference switch: status after a settling count
      if (reference_status_r != reference_select_r &&
          (reference_select_r ? int_s2_r : ext_s2_r)) begin
        if (rsw_cnt_r == `CGM_SWITCH_CYC - 1) begin
          rsw_cnt_r <= 2'h0;
          reference_status_r <= reference_select_r;
          acq_cnt_r <= FLL_ACQ_CYC;
        end else begin
          rsw_cnt_r <= rsw_cnt_r + 2'h1;
        end
      end else begin
        rsw_cnt_r <= 2'h0;
      end
      // source switch, kept when target unavailable
      if (source_status_r != source_select_r && src_ok && !in_stop) begin
        if (sw_cnt_r == `CGM_SWITCH_CYC - 1) begin
          sw_cnt_r <= 2'h0;
          source_status_r <= source_select_r;
        end else begin
          sw_cnt_r <= sw_cnt_r + 2'h1;
        end
      end else begin
        sw_cnt_r <= 2'h0;
      end
      // range switch delay and fll acquisition
      if (dco_cnt_r != 2'h0) begin
        dco_cnt_r <= dco_cnt_r - 2'h1;
        if (dco_cnt_r == 2'h1)
          range_rb_r <= osc_range_select_r;
      end
      // pll lock tracking
      if (pll_enable_o && !in_stop) begin
        if (pll_locked_flag_r && !lck_s2_r)
          pll_unlock_event_r <= 1'b1;
        pll_locked_flag_r <= lck_s2_r;
      end
      // stop entry and exit
      if (stop_r == `CGM_STOP_NONE && in_stop) begin
        stop_r <= stop_s2_r;
        stop_src_r <= reference_select_r ? `CGM_SRC_INT : `CGM_SRC_EXT;
        stop_pll_r <= (source_status_r == `CGM_SRC_LOOP) && pll_select_r;
      end else if (stop_r != `CGM_STOP_NONE && !in_stop) begin
        stop_r <= `CGM_STOP_NONE;
        if (stop_pll_r && stop_r != `CGM_STOP_NORMAL) begin
          source_select_r <= stop_src_r;
          source_status_r <= stop_src_r;
          pll_stop_keep_bit_r <= 1'b0;
          pll_locked_flag_r <= 1'b0;
        end else if (stop_pll_r && !pll_stop_keep_bit_r && stop_src_r == `CGM_SRC_EXT) begin
          source_select_r <= `CGM_SRC_EXT;
          source_status_r <= `CGM_SRC_EXT;
          pll_locked_flag_r <= 1'b0;
        end
        // after a normal stop with the keep bit set, lock and engaged mode carry on
      end
      // read data, one cycle after the strobe
      if (rd_i) begin
        case (addr_i)
          `CGM_OFS_CTRL1: rdata_o <= {source_select_r, 3'h0, reference_select_r,
            internal_ref_out_enable_r, internal_ref_stop_keep_r};
          `CGM_OFS_CTRL2: rdata_o <= {6'h00, low_power_bypass_r, internal_ref_speed_r};
          `CGM_OFS_RANGE: rdata_o <= {6'h00, range_rb_r};
          `CGM_OFS_PLLC: rdata_o <= {1'b0, pll_out_enable_r, pll_stop_keep_bit_r, pll_select_r, 4'h0};
          `CGM_OFS_STAT: rdata_o <= {1'b0, (acq_cnt_r == 32'h0), pll_unlock_event_r,
            reference_status_r, source_status_r, pll_locked_flag_r, 1'b0};
          `CGM_OFS_STOP: rdata_o <= {6'h00, stop_r};
          default: rdata_o <= 8'h00;
        endcase
      end else begin
        rdata_o <= 8'h00;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // clock outputs; during stop everything static but the kept clocks
  // main mux follows status, which moves after a clean changeover or at once on exit from a pll-engaged stop, unless normal with keep bit set or internal reference
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      main_sel_o <= `CGM_SRC_LOOP;
    end else begin
      main_sel_o <= source_status_r;
    end
  end

  // fll off in stop and in both low-power bypass modes
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      fll_enable_o <= 1'b1;
    end else begin
      fll_enable_o <= !in_stop && !bypass_lowpower_external && !bypass_lowpower_internal && !pll_select_r &&
        !(low_power_bypass_r && source_status_r != `CGM_SRC_LOOP);
    end
  end

  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      pll_enable_o <= 1'b0;
    end else begin
      pll_enable_o <= !bypass_lowpower_external && !bypass_lowpower_internal && (pll_select_r || pll_out_enable_r) && pll_keep;
    end
  end

  // gate held shut until lock, so no runt pulses leave the block
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      pll_clk_gate_o <= 1'b0;
    end else begin
      pll_clk_gate_o <= pll_out_enable_r && pll_locked_flag_r && !bypass_lowpower_external && pll_keep;
    end
  end

  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      ir_clk_gate_o <= 1'b0;
    end else begin
      ir_clk_gate_o <= internal_ref_out_enable_r && ir_keep;
    end
  end

  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      fll_locked_o <= 1'b0;
    end else begin
      fll_locked_o <= (acq_cnt_r == 32'h0) && !in_stop;
    end
  end

  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      dco_range_o <= `CGM_RANGE_RST;
    end else if (dco_cnt_r == 2'h1) begin
      dco_range_o <= osc_range_select_r;
    end
  end
endmodule // cgm_mode_ctrl
`default_nettype wire

// File: cgm_mode_ctrl_properties.sv
// port assertions for the clock generator mode control
`default_nettype none
module cgm_mode_ctrl_props (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // register port
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  // chip state
  input wire logic [1:0] stop_kind_i,
  // clock control
  input wire logic [1:0] main_sel_o,
  input wire logic fll_enable_o,
  input wire logic pll_enable_o,
  input wire logic pll_clk_gate_o,
  input wire logic fll_locked_o,
  input wire logic [1:0] dco_range_o
);
  ////////////////////////////////////////
  // shadow of the low-power bit, since range writes depend on it
  logic lp_r;
  logic [1:0] rng_r;
  logic rng_wr;
  assign rng_wr = wr_i && addr_i == 4'h2;
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      lp_r <= 1'b0;
    end else if (wr_i && addr_i == 4'h1) begin
      lp_r <= wdata_i[1];
    end
    if (rng_wr) begin
      rng_r <= wdata_i[1:0];
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  ////////////////////////////////////////
  reset_mode_a: assert property (disable iff (1'b0) srst_i |=> main_sel_o == 2'h0 && fll_enable_o)
    else $error("reset mode wrong");
  stop_fll_a: assert property (stop_kind_i != 2'h0 [*5] |-> !fll_enable_o && !fll_locked_o)
    else $error("fll running in stop");
  stop_src_a: assert property (stop_kind_i != 2'h0 [*5] |=> $stable(main_sel_o))
    else $error("source moved in stop");
  lp_stop_pll_a: assert property (stop_kind_i[1] [*5] |-> !pll_clk_gate_o)
    else $error("pll clock on in low-power stop");
  bypass_lowpower_external_loops_a: assert property ((lp_r && main_sel_o == 2'h2) [*3] |-> !fll_enable_o && !pll_enable_o)
    else $error("loop on in bypass low power");
  range_apply_a: assert property (rng_wr && !lp_r |-> ##[1:4] dco_range_o == rng_r)
    else $error("range not applied");
  range_relock_a: assert property (rng_wr && !lp_r |-> ##[1:4] !fll_locked_o)
    else $error("fll not relocking");
  range_lp_a: assert property (rng_wr && lp_r |=> $stable(dco_range_o) [*4])
    else $error("range taken while low power");
  cover property (rng_wr && !lp_r);
  cover property (stop_kind_i == 2'h3 [*5]);
  cover property (lp_r && main_sel_o == 2'h2);
endmodule // cgm_mode_ctrl_props
bind cgm_mode_ctrl cgm_mode_ctrl_props i_cgm_mode_ctrl_props (.*);
`default_nettype wire

// File: cgm_mode_ctrl_test.sv
// self-checking bench for the clock generator mode control
`default_nettype none
module cgm_mode_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [1:0] stop_kind_i = 2'h0;
  logic ext_ref_ok_i = 1'b1;
  logic int_ref_ok_i = 1'b1;
  logic pll_lock_raw_i = 1'b1;
  wire [7:0] rdata_o;
  wire [1:0] main_sel_o;
  wire [1:0] dco_range_o;
  wire fll_enable_o, pll_enable_o, pll_clk_gate_o, ir_clk_gate_o, fll_locked_o;
  int errors = 0;
  int compares = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  // short acquisition keeps the run brief
  cgm_mode_ctrl #(.FLL_ACQ_CYC(50)) i_cgm_mode_ctrl (.*);
  ////////////////////////////////////////
  task automatic conclude();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m, input string n);
    @(posedge sys_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 cmp(n, e, rdata_o & m);
  endtask
  // switching time depends on synchronisers, so poll with a limit
  task automatic wsel(input logic [1:0] e);
    int k;
    for (k = 0; k < 20 && main_sel_o !== e; k++) cyc(1);
    cmp("main_sel", {6'h0, e}, {6'h0, main_sel_o});
    if (k == 20) conclude();
  endtask
  task automatic stp(input logic [1:0] k);
    @(posedge sys_clk_i) stop_kind_i <= k;
    cyc(6);
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    cmp("main_sel", 8'h00, {6'h0, main_sel_o});
    cmp("fll_en", 8'h01, {7'h0, fll_enable_o});
    rd(4'h0, 8'h04, 8'hc7, "ctrl1");
    $display("test reset done");
  endtask
  task automatic t_range();
    cyc(60);
    wr(4'h2, 8'h01);
    cyc(5);
    cmp("dco_range", 8'h01, {6'h0, dco_range_o});
    cmp("fll_locked", 8'h00, {7'h0, fll_locked_o});
    cyc(60);
    cmp("fll_locked", 8'h01, {7'h0, fll_locked_o});
    rd(4'h2, 8'h01, 8'h03, "range");
    $display("test range done");
  endtask
  task automatic t_src();
    wr(4'h0, 8'h80);
    wsel(2'h2);
    cmp("fll_locked", 8'h00, {7'h0, fll_locked_o});
    rd(4'h4, 8'h08, 8'h1c, "status");
    @(posedge sys_clk_i) int_ref_ok_i <= 1'b0;
    wr(4'h0, 8'h40);
    cyc(10);
    cmp("main_sel", 8'h02, {6'h0, main_sel_o});
    @(posedge sys_clk_i) int_ref_ok_i <= 1'b1;
    wsel(2'h1);
    wr(4'h0, 8'h80);
    wsel(2'h2);
    $display("test source done");
  endtask
  task automatic t_bypass_lowpower_external();
    wr(4'h3, 8'h40);
    wr(4'h1, 8'h02);
    cyc(4);
    cmp("fll_en", 8'h00, {7'h0, fll_enable_o});
    cmp("pll_en", 8'h00, {7'h0, pll_enable_o});
    wr(4'h2, 8'h03);
    cyc(6);
    cmp("dco_range", 8'h01, {6'h0, dco_range_o});
    wr(4'h1, 8'h00);
    cyc(4);
    cmp("fll_en", 8'h01, {7'h0, fll_enable_o});
    $display("test bypass done");
  endtask
  task automatic t_stop();
    wr(4'h0, 8'h83);
    stp(2'h1);
    cmp("fll_en", 8'h00, {7'h0, fll_enable_o});
    cmp("ir_gate", 8'h01, {7'h0, ir_clk_gate_o});
    stp(2'h2);
    cmp("ir_gate", 8'h00, {7'h0, ir_clk_gate_o});
    wr(4'h1, 8'h01);
    cyc(6);
    cmp("ir_gate", 8'h01, {7'h0, ir_clk_gate_o});
    stp(2'h0);
    wr(4'h1, 8'h00);
    $display("test stop done");
  endtask
  task automatic t_lls();
    wr(4'h3, 8'h30);
    wr(4'h0, 8'h00);
    wsel(2'h0);
    stp(2'h3);
    stp(2'h0);
    cmp("main_sel", 8'h02, {6'h0, main_sel_o});
    rd(4'h3, 8'h10, 8'h30, "pll_ctrl");
    rd(4'h4, 8'h08, 8'h2c, "status");
    $display("test lls exit done");
  endtask
  task automatic t_norm();
    wr(4'h3, 8'h70);
    wr(4'h0, 8'h00);
    wsel(2'h0);
    cyc(4);
    stp(2'h1);
    cmp("pll_en", 8'h01, {7'h0, pll_enable_o});
    cmp("pll_gate", 8'h01, {7'h0, pll_clk_gate_o});
    stp(2'h0);
    cmp("main_sel", 8'h00, {6'h0, main_sel_o});
    rd(4'h4, 8'h02, 8'h0e, "status");
    wr(4'h3, 8'h50);
    stp(2'h1);
    cmp("pll_gate", 8'h00, {7'h0, pll_clk_gate_o});
    stp(2'h0);
    cmp("main_sel", 8'h02, {6'h0, main_sel_o});
    rd(4'h4, 8'h08, 8'h2c, "status");
    $display("test normal stop done");
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (10) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    cyc(1);
    t_reset();
    t_range();
    t_src();
    t_bypass_lowpower_external();
    t_stop();
    t_lls();
    t_norm();
    conclude();
  end
endmodule // cgm_mode_ctrl_test
`default_nettype wire
